// ### alu_pkg.sv
// package: operation codes, flag layout, request and result structs
package alu_pkg;

   localparam int DATA_W = 8;
   localparam int NIB_W = 4;

   // flag vector bit positions, as packed in flags_t
   localparam int FLAG_Z_POS = 3;
   localparam int FLAG_C_POS = 2;
   localparam int FLAG_HC_POS = 1;
   localparam int FLAG_OVF_POS = 0;

   // values after reset
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] MEM_RST = 8'h00;
   localparam logic [7:0] MEM_ADDR_RST = 8'h00;

   // cycles from request to result
   localparam int RESULT_LATENCY = 1;

   // operations of this datapath slice
   typedef enum logic [4:0] {
      OP_NOP      = 5'h00,
      OP_SUB_MA   = 5'h01,
      OP_SUBC_AM  = 5'h02,
      OP_SUBC_MA  = 5'h03,
      OP_SUBC_A   = 5'h04,
      OP_SUBC_M   = 5'h05,
      OP_INC_M    = 5'h06,
      OP_DEC_M    = 5'h07,
      OP_CLEAR_M  = 5'h08,
      OP_SRA      = 5'h09,
      OP_SRCA     = 5'h0a,
      OP_SRM      = 5'h0b,
      OP_SRCM     = 5'h0c,
      OP_SLA      = 5'h0d,
      OP_SLCA     = 5'h0e,
      OP_SLM      = 5'h0f,
      OP_SLCM     = 5'h10,
      OP_SWAPA    = 5'h11,
      OP_SWAPM    = 5'h12
   } alu_op_t;

   typedef struct packed {
      logic zero_flag;
      logic carry_flag;
      logic half_carry_flag;
      logic overflow_flag;
   } flags_t;

   // one request: operation, memory address
   typedef struct packed {
      alu_op_t op;
      logic [7:0] addr;
   } alu_req_t;

   // one combinational result
   typedef struct packed {
      logic [7:0] value;
      logic to_mem;
      logic to_acc;
      logic set_arith;
      logic set_carry_only;
      flags_t flags;
   } alu_res_t;

endpackage : alu_pkg

// ### sub_unit.sv
// 8-bit borrow subtractor with half-borrow and overflow
`timescale 1ns/1ps
module sub_unit
   import alu_pkg::*;
(
   // operands
   input wire logic [7:0] min_i,
   input wire logic [7:0] sub_i,
   input wire logic borrow_i,
   // result
   output logic [7:0] diff_o,
   output flags_t flags_o
);

   logic [8:0] full;
   logic [4:0] low;

   always_comb
   begin
      // minuend plus two's complement of subtrahend and borrow
      full = {1'b0, min_i} - {1'b0, sub_i} - {8'h00, borrow_i};
      low = {1'b0, min_i[3:0]} - {1'b0, sub_i[3:0]} - {4'h0, borrow_i};
      diff_o = full[7:0];
      flags_o.zero_flag = (full[7:0] == 8'h00);
      flags_o.carry_flag = full[8];
      flags_o.half_carry_flag = low[4];
      flags_o.overflow_flag = (min_i[7] != sub_i[7]) && (full[7] != min_i[7]);
   end

endmodule : sub_unit

// ### shift_unit.sv
// shifts, rotates through carry and nibble swap
`timescale 1ns/1ps
module shift_unit
   import alu_pkg::*;
(
   // operands
   input wire logic [7:0] val_i,
   input wire logic carry_i,
   input wire logic right_i,
   input wire logic rotate_i,
   input wire logic swap_i,
   // result
   output logic [7:0] val_o,
   output logic carry_o
);

   logic fill;

   always_comb
   begin
      fill = rotate_i ? carry_i : 1'b0;
      if (swap_i)
      begin
         val_o = {val_i[3:0], val_i[7:4]};
         carry_o = carry_i;
      end
      else if (right_i)
      begin
         val_o = {fill, val_i[7:1]};
         carry_o = val_i[0];
      end
      else
      begin
         val_o = {val_i[6:0], fill};
         carry_o = val_i[7];
      end
   end

endmodule : shift_unit

// ### subtract_shift_alu_ops.sv
// subtract, inc/dec/clear and shift slice of the 8-bit core datapath
`timescale 1ns/1ps
module subtract_shift_alu_ops
   import alu_pkg::*;
#(
   parameter int MEM_DEPTH = 256
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // operation request
   input wire logic req_valid_i,
   input alu_req_t req_i,
   // accumulator and flag load from the rest of the core
   input wire logic acc_load_i,
   input wire logic [7:0] acc_load_data_i,
   input wire logic flags_load_i,
   input flags_t flags_load_data_i,
   // memory load from the rest of the core
   input wire logic mem_load_i,
   input wire logic [7:0] mem_load_addr_i,
   input wire logic [7:0] mem_load_data_i,
   // memory read port
   input wire logic [7:0] mem_rd_addr_i,
   output logic [7:0] mem_rd_data_o,
   // state
   output logic [7:0] acc_o,
   output flags_t flags_o,
   output logic done_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] acc_ff;
   logic [7:0] nxt_acc;
   flags_t flags_ff;
   flags_t nxt_flags;
   // data memory, one byte per address
   logic [7:0] mem_ff [MEM_DEPTH];
   logic [7:0] nxt_mem_data;
   logic [7:0] nxt_mem_addr;
   logic nxt_mem_we;
   logic done_ff;
   logic nxt_done;
   logic [7:0] mem_rd_ff;
   logic [7:0] nxt_mem_rd;

   // ----------------------------------------
   // operand select
   // ----------------------------------------
   logic [7:0] mem_val;
   logic [7:0] sub_min;
   logic [7:0] sub_sub;
   logic sub_borrow;
   logic [7:0] sub_diff;
   flags_t sub_flags;
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   logic sh_carry;
   logic sh_right;
   logic sh_rotate;
   logic sh_swap;
   logic [8:0] inc_full;
   logic [4:0] inc_low;
   alu_res_t res;

   // memory-target operations
   function automatic logic is_mem_op(input alu_op_t op);
      is_mem_op = op inside {OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M, OP_INC_M, OP_DEC_M,
         OP_CLEAR_M, OP_SRM, OP_SRCM, OP_SLM, OP_SLCM, OP_SWAPM};
   endfunction : is_mem_op

   assign mem_val = mem_ff[req_i.addr];

   // subtract operands: minuend, subtrahend, borrow in
   always_comb
   begin
      sub_min = mem_val;
      sub_sub = acc_ff;
      sub_borrow = 1'b0;
      unique case (req_i.op)
         OP_SUB_MA:  ;
         OP_SUBC_AM:
         begin
            sub_min = acc_ff;
            sub_sub = mem_val;
            sub_borrow = flags_ff.carry_flag;
         end
         OP_SUBC_MA: sub_borrow = flags_ff.carry_flag;
         OP_SUBC_A:
         begin
            sub_min = acc_ff;
            sub_sub = 8'h00;
            sub_borrow = flags_ff.carry_flag;
         end
         OP_SUBC_M:
         begin
            sub_sub = 8'h00;
            sub_borrow = flags_ff.carry_flag;
         end
         OP_DEC_M: sub_sub = 8'h01;
         default: ;
      endcase
   end

   // ----------------------------------------
   // arithmetic and shift units
   // ----------------------------------------
   sub_unit sub_unit_i (
      .min_i(sub_min),
      .sub_i(sub_sub),
      .borrow_i(sub_borrow),
      .diff_o(sub_diff),
      .flags_o(sub_flags)
   );

   // shifter control decoded from the operation
   always_comb
   begin
      sh_in = is_mem_op(req_i.op) ? mem_val : acc_ff;
      sh_right = req_i.op inside {OP_SRA, OP_SRCA, OP_SRM, OP_SRCM};
      sh_rotate = req_i.op inside {OP_SRCA, OP_SRCM, OP_SLCA, OP_SLCM};
      sh_swap = req_i.op inside {OP_SWAPA, OP_SWAPM};
   end

   shift_unit shift_unit_i (
      .val_i(sh_in),
      .carry_i(flags_ff.carry_flag),
      .right_i(sh_right),
      .rotate_i(sh_rotate),
      .swap_i(sh_swap),
      .val_o(sh_out),
      .carry_o(sh_carry)
   );

   // ----------------------------------------
   // result select
   // ----------------------------------------
   // subtractor result unless the operation overrides it
   always_comb
   begin
      inc_full = {1'b0, mem_val} + 9'h001;
      inc_low = {1'b0, mem_val[3:0]} + 5'h01;
      res.value = sub_diff;
      res.to_mem = is_mem_op(req_i.op);
      res.to_acc = 1'b0;
      res.set_arith = 1'b0;
      res.set_carry_only = 1'b0;
      res.flags = sub_flags;
      unique case (req_i.op)
         OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M, OP_DEC_M:
            res.set_arith = 1'b1;
         OP_SUBC_AM, OP_SUBC_A:
         begin
            res.to_acc = 1'b1;
            res.set_arith = 1'b1;
         end
         // own carry chain: carry is the carry out of bit 7
         OP_INC_M:
         begin
            res.value = inc_full[7:0];
            res.set_arith = 1'b1;
            res.flags.zero_flag = (inc_full[7:0] == 8'h00);
            res.flags.carry_flag = inc_full[8];
            res.flags.half_carry_flag = inc_low[4];
            res.flags.overflow_flag = ~mem_val[7] & inc_full[7];
         end
         OP_CLEAR_M: res.value = 8'h00;
         OP_SRA, OP_SRCA, OP_SLA, OP_SLCA:
         begin
            res.value = sh_out;
            res.to_acc = 1'b1;
            res.set_carry_only = 1'b1;
         end
         OP_SRM, OP_SRCM, OP_SLM, OP_SLCM:
         begin
            res.value = sh_out;
            res.set_carry_only = 1'b1;
         end
         OP_SWAPA:
         begin
            res.value = sh_out;
            res.to_acc = 1'b1;
         end
         OP_SWAPM: res.value = sh_out;
         // unused codes: nothing written, done still pulses
         default: res.to_mem = 1'b0;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_acc = acc_ff;
      nxt_flags = flags_ff;
      nxt_mem_we = 1'b0;
      nxt_mem_addr = req_i.addr;
      nxt_mem_data = res.value;
      nxt_done = 1'b0;
      if (req_valid_i)
      begin
         nxt_done = 1'b1;
         if (res.to_acc)
            nxt_acc = res.value;
         if (res.to_mem)
            nxt_mem_we = 1'b1;
         if (res.set_arith)
            nxt_flags = res.flags;
         else if (res.set_carry_only)
            nxt_flags.carry_flag = sh_carry;
      end
      else
      begin
         // core loads only while no operation is taken
         if (acc_load_i)
            nxt_acc = acc_load_data_i;
         if (flags_load_i)
            nxt_flags = flags_load_data_i;
         if (mem_load_i)
         begin
            nxt_mem_we = 1'b1;
            nxt_mem_addr = mem_load_addr_i;
            nxt_mem_data = mem_load_data_i;
         end
      end
      // read port: byte shows one edge after its address
      nxt_mem_rd = mem_ff[mem_rd_addr_i];
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         acc_ff <= ACC_RST;
         flags_ff <= FLAGS_RST;
         done_ff <= 1'b0;
         mem_rd_ff <= MEM_RST;
      end
      else
      begin
         acc_ff <= nxt_acc;
         flags_ff <= nxt_flags;
         done_ff <= nxt_done;
         mem_rd_ff <= nxt_mem_rd;
      end
   end

   // ----------------------------------------
   // memory array, one write per cycle
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < MEM_DEPTH; gi++)
      begin : g_mem
         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
               mem_ff[gi] <= MEM_RST;
            else if (nxt_mem_we && (nxt_mem_addr == 8'(gi)))
               mem_ff[gi] <= nxt_mem_data;
         end
      end
   endgenerate

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign acc_o = acc_ff;
   assign flags_o = flags_ff;
   assign done_o = done_ff;
   assign mem_rd_data_o = mem_rd_ff;

endmodule : subtract_shift_alu_ops

// ### alu_ops_monitor.sv
// checker for the subtract and shift slice
`timescale 1ns/1ps
module alu_ops_monitor
   import alu_pkg::*;
#(
   parameter int MEM_DEPTH = 256
)
(
   // clock, reset, request
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input alu_req_t req_i,
   // state
   input wire logic [7:0] acc_o,
   input flags_t flags_o,
   input wire logic done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   alu_op_t op;
   assign op = req_valid_i ? req_i.op : OP_NOP;
   a_done_pulse:
   assert property (req_valid_i |=> done_o) else $error("done missing");
   a_done_quiet:
   assert property (!req_valid_i |=> !done_o) else $error("done without request");
   a_rshift_acc:
   assert property (op == OP_SRA |=> acc_o == {1'b0, $past(acc_o[7:1])}
      && flags_o.carry_flag == $past(acc_o[0])) else $error("right shift acc wrong");
   a_src_acc:
   assert property (op == OP_SRCA |=> acc_o == {$past(flags_o.carry_flag), $past(acc_o[7:1])}
      && flags_o.carry_flag == $past(acc_o[0])) else $error("src acc wrong");
   a_lshift_acc:
   assert property (op == OP_SLA |=> acc_o == {$past(acc_o[6:0]), 1'b0}
      && flags_o.carry_flag == $past(acc_o[7])) else $error("left shift acc wrong");
   a_swap_acc:
   assert property (op == OP_SWAPA |=> acc_o == {$past(acc_o[3:0]), $past(acc_o[7:4])}
      && $stable(flags_o)) else $error("swap acc wrong");
   a_subc_acc:
   assert property (op == OP_SUBC_A |=> acc_o == $past(acc_o) - $past(flags_o.carry_flag)
      && flags_o.zero_flag == (acc_o == 8'h00)) else $error("subc acc wrong");
   a_flags_kept:
   assert property (op inside {OP_CLEAR_M, OP_SWAPM} |=> $stable(flags_o) && $stable(acc_o))
      else $error("flags or acc moved");
   c_sub: cover property (op == OP_SUB_MA);
   c_b2b: cover property (done_o && req_valid_i);
   c_swap: cover property (op == OP_SWAPM);
endmodule : alu_ops_monitor

bind subtract_shift_alu_ops alu_ops_monitor #(.MEM_DEPTH(MEM_DEPTH)) alu_ops_monitor_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
   .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o));

// ### subtract_shift_alu_ops_test.sv
// directed bench for the subtract and shift slice
`timescale 1ns/1ps
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t %h %h", $time, g, e); end end
module subtract_shift_alu_ops_test
   import alu_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req_valid_i = 1'b0;
   alu_req_t req_i = '0;
   logic acc_load_i = 1'b0;
   logic flags_load_i = 1'b0;
   logic mem_load_i = 1'b0;
   logic [7:0] acc_load_data_i = 8'h00;
   logic [7:0] mem_load_data_i = 8'h00;
   logic [7:0] ad = 8'h05;
   flags_t flags_load_data_i = '0;
   logic [7:0] mem_rd_data_o;
   logic [7:0] acc_o;
   flags_t flags_o;
   logic done_o;
   int n_fail = 0;
   int samples_checked = 0;
   always #20 clk_i = ~clk_i;
   subtract_shift_alu_ops subtract_shift_alu_ops_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .acc_load_i(acc_load_i),
      .acc_load_data_i(acc_load_data_i), .flags_load_i(flags_load_i),
      .flags_load_data_i(flags_load_data_i), .mem_load_i(mem_load_i),
      .mem_load_addr_i(ad), .mem_load_data_i(mem_load_data_i), .mem_rd_addr_i(ad),
      .mem_rd_data_o(mem_rd_data_o), .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o));
   // ---
   // preload, one op, check both destinations
   // ---
   task t(input alu_op_t o, input logic [7:0] a, m, ev, input flags_t f, ef);
      logic d;
      d = !(o inside {OP_SUBC_AM, OP_SUBC_A, OP_SRA, OP_SRCA, OP_SLA, OP_SLCA, OP_SWAPA});
      @(negedge clk_i);
      {acc_load_i, flags_load_i, mem_load_i} = 3'h7;
      acc_load_data_i = a;
      flags_load_data_i = f;
      mem_load_data_i = m;
      @(negedge clk_i);
      {acc_load_i, flags_load_i, mem_load_i} = 3'h0;
      req_valid_i = 1'b1;
      req_i = '{o, ad};
      @(negedge clk_i);
      req_valid_i = 1'b0;
      `CK(done_o, 1'b1)
      `CK(acc_o, d ? a : ev)
      `CK(flags_o, ef)
      @(negedge clk_i);
      `CK(done_o, 1'b0)
      `CK(mem_rd_data_o, d ? ev : m)
   endtask : t
   task sub_ops;
      t(OP_SUB_MA, 8'h01, 8'h80, 8'h7f, 4'h0, 4'h3);
      t(OP_SUB_MA, 8'h80, 8'h80, 8'h00, 4'h0, 4'h8);
      t(OP_SUBC_AM, 8'h00, 8'h00, 8'hff, 4'h4, 4'h6);
      t(OP_SUBC_MA, 8'h20, 8'h50, 8'h2f, 4'h4, 4'h2);
      t(OP_SUBC_A, 8'h01, 8'h33, 8'h00, 4'h4, 4'h8);
      t(OP_SUBC_M, 8'h5a, 8'h80, 8'h7f, 4'h4, 4'h3);
   endtask : sub_ops
   task incdec_ops;
      t(OP_INC_M, 8'h5a, 8'h7f, 8'h80, 4'h0, 4'h3);
      t(OP_DEC_M, 8'h5a, 8'h80, 8'h7f, 4'h0, 4'h3);
      t(OP_DEC_M, 8'h5a, 8'h01, 8'h00, 4'h6, 4'h8);
   endtask : incdec_ops
   task clear_swap;
      t(OP_CLEAR_M, 8'h5a, 8'ha5, 8'h00, 4'h7, 4'h7);
      t(OP_SWAPA, 8'h12, 8'h33, 8'h21, 4'h5, 4'h5);
      t(OP_SWAPM, 8'h5a, 8'ha7, 8'h7a, 4'ha, 4'ha);
   endtask : clear_swap
   task shift_ops;
      t(OP_SRA, 8'h81, 8'h33, 8'h40, 4'hb, 4'hf);
      t(OP_SRCA, 8'h02, 8'h33, 8'h81, 4'h4, 4'h0);
      t(OP_SRM, 8'h5a, 8'h01, 8'h00, 4'h0, 4'h4);
      t(OP_SRCM, 8'h5a, 8'h80, 8'hc0, 4'h4, 4'h0);
      t(OP_SLA, 8'h81, 8'h33, 8'h02, 4'h0, 4'h4);
      t(OP_SLCA, 8'h40, 8'h33, 8'h81, 4'hf, 4'hb);
      t(OP_SLM, 8'h5a, 8'h80, 8'h00, 4'h0, 4'h4);
      t(OP_SLCM, 8'h5a, 8'h01, 8'h03, 4'h4, 4'h0);
   endtask : shift_ops
   // back to back inc, dec at top address; load ignored meanwhile
   task b2b;
      ad = 8'hff;
      t(OP_NOP, 8'h3c, 8'hff, 8'hff, 4'h0, 4'h0);
      req_valid_i = 1'b1;
      req_i = '{OP_INC_M, ad};
      acc_load_i = 1'b1;
      acc_load_data_i = 8'h00;
      @(negedge clk_i);
      req_i = '{OP_DEC_M, ad};
      `CK(done_o, 1'b1)
      `CK(flags_o, 4'he)
      @(negedge clk_i);
      req_valid_i = 1'b0;
      acc_load_i = 1'b0;
      `CK(flags_o, 4'h6)
      `CK(acc_o, 8'h3c)
      @(negedge clk_i);
      `CK(mem_rd_data_o, 8'hff)
   endtask : b2b
   task wrap_up;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (2000) @(posedge clk_i);
      n_fail++;
      wrap_up;
   end
   initial
   begin
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      `CK(acc_o, 8'h00)
      `CK(flags_o, 4'h0)
      `CK(done_o, 1'b0)
      sub_ops;
      incdec_ops;
      clear_swap;
      shift_ops;
      b2b;
      wrap_up;
   end
endmodule : subtract_shift_alu_ops_test
